// ===== logic/rmp_pin_mux.sv
// Top of the reset mode pin multiplexer: mode latches, flag pins,
// external bus, host port, shared interrupts and serial alternates.
// Assumes the processor core drives the core_ inputs on this clock.
`timescale 1ns/1ps
module rmp_pin_mux (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [rmp_pkg::FLAG_W-1:0] flag_pin_in,
    output logic [rmp_pkg::FLAG_W-1:0] flag_pin_out,
    output logic [rmp_pkg::FLAG_W-1:0] flag_pin_oe,
    input wire logic [rmp_pkg::FLAG_W-1:0] core_flag_dir,
    input wire logic [rmp_pkg::FLAG_W-1:0] core_flag_out,
    output logic [rmp_pkg::FLAG_W-1:0] core_flag_in,
    output logic mode_host,
    output logic mode_b,
    output logic mode_a,
    output logic mode_valid,
    output logic [rmp_pkg::ADDR_W-1:0] external_address_bus,
    output logic [rmp_pkg::ADDR_W-1:0] external_address_oe,
    input wire logic [rmp_pkg::DATA_W-1:0] external_data_in,
    output logic [rmp_pkg::DATA_W-1:0] external_data_out,
    output logic [rmp_pkg::DATA_W-1:0] external_data_oe,
    input wire logic [rmp_pkg::ADDR_W-1:0] core_addr,
    input wire logic [rmp_pkg::DATA_W-1:0] core_data_out,
    input wire logic core_data_drive,
    input wire logic core_byte_access,
    input wire logic [rmp_pkg::BYTE_HI_W-1:0] core_byte_addr_hi,
    output logic [rmp_pkg::DATA_W-1:0] core_data_in,
    input wire logic [rmp_pkg::HOST_W-1:0] host_port_addr_data_in,
    output logic [rmp_pkg::HOST_W-1:0] host_port_addr_data_out,
    output logic [rmp_pkg::HOST_W-1:0] host_port_addr_data_oe,
    input wire logic host_port_write_enable_n,
    input wire logic host_port_read_enable_n,
    input wire logic host_port_address_latch,
    input wire logic host_port_select_n,
    output logic host_port_acknowledge_n,
    output logic host_port_acknowledge_oe,
    input wire logic [rmp_pkg::HOST_W-1:0] core_host_data_out,
    input wire logic core_host_data_drive,
    input wire logic core_host_ack,
    output logic [rmp_pkg::HOST_W-1:0] core_host_data_in,
    output logic core_host_write,
    output logic core_host_read,
    output logic core_host_latch,
    output logic core_host_select,
    input wire logic [rmp_pkg::SP_W-1:0] second_serial_port_in,
    output logic [rmp_pkg::SP_W-1:0] second_serial_port_out,
    output logic [rmp_pkg::SP_W-1:0] second_serial_port_oe,
    input wire logic core_sp_alt,
    input wire logic [rmp_pkg::SP_W-1:0] core_sp_out,
    input wire logic [rmp_pkg::SP_W-1:0] core_sp_oe,
    output logic [rmp_pkg::SP_W-1:0] core_sp_in,
    input wire logic serial_alt_flag_output,
    output logic serial_alt_flag_input,
    input wire logic [rmp_pkg::IRQ_N-1:0] core_irq_edge,
    input wire logic [rmp_pkg::IRQ_N-1:0] core_irq_clear,
    output logic [rmp_pkg::IRQ_N-1:0] core_irq_req
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        rmp_pkg::rmp_phase_t phase;
        logic mode_c;
        logic mode_b;
        logic mode_a;
        logic [rmp_pkg::FLAG_W-1:0] flag_out;
        logic [rmp_pkg::FLAG_W-1:0] flag_oe;
        logic [rmp_pkg::FLAG_W-1:0] flag_in;
        logic [rmp_pkg::ADDR_W-1:0] addr;
        logic [rmp_pkg::ADDR_W-1:0] addr_oe;
        logic [rmp_pkg::DATA_W-1:0] data;
        logic [rmp_pkg::DATA_W-1:0] data_oe;
        logic [rmp_pkg::DATA_W-1:0] data_in;
        logic [rmp_pkg::HOST_W-1:0] iad;
        logic [rmp_pkg::HOST_W-1:0] iad_oe;
        logic [rmp_pkg::HOST_W-1:0] iad_in;
        logic ack_n;
        logic ack_oe;
        logic [3:0] host_ctl;
        logic [rmp_pkg::SP_W-1:0] sp_out;
        logic [rmp_pkg::SP_W-1:0] sp_oe;
        logic [rmp_pkg::SP_W-1:0] sp_in;
        logic fi;
        logic [rmp_pkg::IRQ_N-1:0] irq;
    } rmp_top_state_t;

    rmp_top_state_t state_reg;
    rmp_top_state_t state_next;

    localparam rmp_top_state_t STATE_RST = '{
        phase: rmp_pkg::PH_CAPTURE,
        mode_c: rmp_pkg::MODE_C_FULL,
        mode_b: 1'b0,
        mode_a: 1'b0,
        flag_out: rmp_pkg::FLAG_RST,
        flag_oe: rmp_pkg::FLAG_RST,
        flag_in: rmp_pkg::FLAG_RST,
        addr: rmp_pkg::ADDR_RST,
        addr_oe: rmp_pkg::ADDR_RST,
        data: rmp_pkg::DATA_RST,
        data_oe: rmp_pkg::DATA_RST,
        data_in: rmp_pkg::DATA_RST,
        iad: rmp_pkg::HOST_RST,
        iad_oe: rmp_pkg::HOST_RST,
        iad_in: rmp_pkg::HOST_RST,
        ack_n: 1'b1,
        ack_oe: 1'b0,
        host_ctl: 4'h0,
        sp_out: rmp_pkg::SP_RST,
        sp_oe: rmp_pkg::SP_RST,
        sp_in: rmp_pkg::SP_RST,
        fi: 1'b0,
        irq: rmp_pkg::IRQ_RST
    };

    // Level seen on a pin: own drive when enabled, else the outside
    function automatic logic pin_level(
        input logic oe,
        input logic drv,
        input logic outside
    );
        pin_level = oe ? drv : outside;
    endfunction

    // ************************************************************
    // Synchronised pins
    // ************************************************************
    logic [rmp_pkg::SYNC_W-1:0] pins_s;
    logic [rmp_pkg::FLAG_W-1:0] flag_s;
    logic [rmp_pkg::DATA_W-1:0] data_s;
    logic [rmp_pkg::HOST_W-1:0] iad_s;
    logic [3:0] hctl_s;
    logic [rmp_pkg::SP_W-1:0] sp_s;

    rmp_sync u_sync (
        .clk(clk),
        .async_in({flag_pin_in, external_data_in, host_port_addr_data_in,
                   host_port_write_enable_n, host_port_read_enable_n,
                   host_port_address_latch, host_port_select_n,
                   second_serial_port_in}),
        .sync_out(pins_s)
    );

    assign {flag_s, data_s, iad_s, hctl_s, sp_s} = pins_s;

    // ************************************************************
    // Interrupt detectors
    // ************************************************************
    rmp_irq_if irq_bus [rmp_pkg::IRQ_N] ();
    logic [rmp_pkg::IRQ_N-1:0] irq_level_n;
    logic [rmp_pkg::IRQ_N-1:0] irq_edge;
    logic [rmp_pkg::IRQ_N-1:0] irq_req;

    always_comb begin
        // Shared pins feed the detector even while used as a flag
        irq_level_n[rmp_pkg::IRQ_CFG] = pin_level(
            state_reg.flag_oe[rmp_pkg::FLAG_OF_CFG],
            state_reg.flag_out[rmp_pkg::FLAG_OF_CFG],
            flag_s[rmp_pkg::FLAG_OF_CFG]);
        irq_level_n[rmp_pkg::IRQ_L1] = pin_level(
            state_reg.flag_oe[rmp_pkg::FLAG_OF_L1],
            state_reg.flag_out[rmp_pkg::FLAG_OF_L1],
            flag_s[rmp_pkg::FLAG_OF_L1]);
        irq_level_n[rmp_pkg::IRQ_L0] = pin_level(
            state_reg.flag_oe[rmp_pkg::FLAG_OF_L0],
            state_reg.flag_out[rmp_pkg::FLAG_OF_L0],
            flag_s[rmp_pkg::FLAG_OF_L0]);
        irq_level_n[rmp_pkg::IRQ_E] = pin_level(
            state_reg.flag_oe[rmp_pkg::FLAG_OF_E],
            state_reg.flag_out[rmp_pkg::FLAG_OF_E],
            flag_s[rmp_pkg::FLAG_OF_E]);
        // Serial alternates read high (idle) unless selected
        irq_level_n[rmp_pkg::IRQ_SP0] = ~core_sp_alt |
            sp_s[rmp_pkg::SP_RFS];
        irq_level_n[rmp_pkg::IRQ_SP1] = ~core_sp_alt |
            sp_s[rmp_pkg::SP_TFS];
        // Fixed slots ignore software, others follow it
        irq_edge = (rmp_pkg::IRQ_FIXED_MASK & rmp_pkg::IRQ_FIXED_EDGE) |
            (~rmp_pkg::IRQ_FIXED_MASK & core_irq_edge);
    end

    genvar gi;
    generate
        for (gi = 0; gi < rmp_pkg::IRQ_N; gi++) begin : g_irq
            assign irq_bus[gi].level_n = irq_level_n[gi];
            assign irq_bus[gi].edge_mode = irq_edge[gi];
            assign irq_bus[gi].clear = core_irq_clear[gi];
            assign irq_req[gi] = irq_bus[gi].req;
            rmp_irq_det u_det (
                .clk(clk),
                .rstn(rstn),
                .irq(irq_bus[gi].det)
            );
        end
    endgenerate

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg.phase)
            rmp_pkg::PH_CAPTURE: begin
                // First edge after release: pins still show reset levels
                state_next.mode_c = flag_s[rmp_pkg::MODE_C_BIT];
                state_next.mode_b = flag_s[rmp_pkg::MODE_B_BIT];
                state_next.mode_a = flag_s[rmp_pkg::MODE_A_BIT];
                state_next.phase = rmp_pkg::PH_RUN;
            end
            rmp_pkg::PH_RUN: begin
                // Mode pins now plain flags; mode fields left as caught
                state_next.flag_oe = core_flag_dir;
                state_next.flag_out = core_flag_out;
                state_next.flag_in = flag_s;
                state_next.irq = irq_req;
                if (state_reg.mode_c == rmp_pkg::MODE_C_FULL) begin
                    state_next.addr = core_addr;
                    state_next.addr_oe = '1;
                    state_next.data = core_data_out;
                    state_next.data_oe = {rmp_pkg::DATA_W{core_data_drive}};
                    state_next.data_in = data_s;
                    if (core_byte_access) begin
                        state_next.data[rmp_pkg::DATA_W-1 -: 8] =
                            core_byte_addr_hi;
                        state_next.data_oe[rmp_pkg::DATA_W-1 -: 8] =
                            8'hFF;
                    end
                    state_next.iad = rmp_pkg::HOST_RST;
                    state_next.iad_oe = rmp_pkg::HOST_RST;
                    state_next.iad_in = rmp_pkg::HOST_RST;
                    state_next.ack_n = 1'b1;
                    state_next.ack_oe = 1'b0;
                    state_next.host_ctl = 4'h0;
                end else begin
                    // Only bit 0 and the top sixteen lines are bus pins
                    state_next.addr = {13'h0000, core_addr[0]};
                    state_next.addr_oe = rmp_pkg::ADDR_OE_HOST;
                    state_next.data = {core_data_out[rmp_pkg::HOST_W-1:0],
                        8'h00};
                    state_next.data_oe = {{rmp_pkg::HOST_W{core_data_drive}},
                        8'h00};
                    state_next.data_in = {8'h00,
                        data_s[rmp_pkg::DATA_W-1:8]};
                    state_next.iad = core_host_data_out;
                    state_next.iad_oe =
                        {rmp_pkg::HOST_W{core_host_data_drive}};
                    state_next.iad_in = iad_s;
                    state_next.ack_n = ~core_host_ack;
                    state_next.ack_oe = 1'b1;
                    // Strobes are active low except the address latch
                    state_next.host_ctl = {~hctl_s[3], ~hctl_s[2],
                        hctl_s[1], ~hctl_s[0]};
                end
                // Serial pin roles follow software at any time
                state_next.sp_out = core_sp_out;
                state_next.sp_oe = core_sp_oe;
                state_next.sp_in = sp_s;
                state_next.fi = 1'b0;
                if (core_sp_alt) begin
                    state_next.sp_out[rmp_pkg::SP_DT] =
                        serial_alt_flag_output;
                    state_next.sp_oe[rmp_pkg::SP_DT] = 1'b1;
                    state_next.sp_oe[rmp_pkg::SP_DR] = 1'b0;
                    state_next.sp_oe[rmp_pkg::SP_RFS] = 1'b0;
                    state_next.sp_oe[rmp_pkg::SP_TFS] = 1'b0;
                    state_next.fi = sp_s[rmp_pkg::SP_DR];
                end
            end
        endcase
    end

    // Outside drivers of the mode pins float after reset, flags take over
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Outputs, all straight from the state register
    // ************************************************************
    assign flag_pin_out = state_reg.flag_out;
    assign flag_pin_oe = state_reg.flag_oe;
    assign core_flag_in = state_reg.flag_in;
    assign mode_host = state_reg.mode_c;
    assign mode_b = state_reg.mode_b;
    assign mode_a = state_reg.mode_a;
    assign mode_valid = (state_reg.phase == rmp_pkg::PH_RUN);
    // Selects come from the core; outside decode uses bit 0 with them
    assign external_address_bus = state_reg.addr;
    assign external_address_oe = state_reg.addr_oe;
    assign external_data_out = state_reg.data;
    assign external_data_oe = state_reg.data_oe;
    assign core_data_in = state_reg.data_in;
    assign host_port_addr_data_out = state_reg.iad;
    assign host_port_addr_data_oe = state_reg.iad_oe;
    assign host_port_acknowledge_n = state_reg.ack_n;
    assign host_port_acknowledge_oe = state_reg.ack_oe;
    assign core_host_data_in = state_reg.iad_in;
    assign core_host_write = state_reg.host_ctl[3];
    assign core_host_read = state_reg.host_ctl[2];
    assign core_host_latch = state_reg.host_ctl[1];
    assign core_host_select = state_reg.host_ctl[0];
    assign second_serial_port_out = state_reg.sp_out;
    assign second_serial_port_oe = state_reg.sp_oe;
    assign core_sp_in = state_reg.sp_in;
    assign serial_alt_flag_input = state_reg.fi;
    assign core_irq_req = state_reg.irq;
endmodule

// ===== logic/rmp_pkg.sv
// Constants, pin positions and types of the reset mode pin multiplexer.
// Assumes one processor clock and an active-low asynchronous reset.
//
// Contract
// - Mode pins are looked at only in reset; afterwards they are flags.
// - The memory mode caught at reset holds until the next reset.
// - Mode C low at reset selects full memory mode.
// - Full mode drives a 14-bit address and a 24-bit data bus.
// - Full mode puts byte address high bits on the top 8 data lines.
// - Mode C high at reset selects host mode with a 16-bit host bus.
// - In host mode the host drives strobes and the device drives ack.
// - Host mode drives only address bit 0 and data lines 23 to 8.
// - Bus pins set only at reset; serial pins switch at any time.
// - Interrupt and flag functions of a shared pin work together.
// - Flag 7 irq is edge or level, flags 5 and 6 level, flag 4 edge.
// - Second serial port pins may be two irqs, a flag in and out.
package rmp_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 24;
    localparam int HOST_W = 16;
    localparam int FLAG_W = 8;
    localparam int BYTE_HI_W = 8;
    localparam int SP_W = 5;
    localparam int IRQ_N = 6;
    localparam int SYNC_W = FLAG_W + DATA_W + HOST_W + 4 + SP_W;
    // ************************************************************
    // Mode pins shared with flags
    // ************************************************************
    localparam int MODE_A_BIT = 0;
    localparam int MODE_B_BIT = 1;
    localparam int MODE_C_BIT = 2;
    localparam logic MODE_C_FULL = 1'b0;
    localparam logic MODE_C_HOST = 1'b1;
    // ************************************************************
    // Interrupt slots and their flag pins
    // ************************************************************
    localparam int IRQ_CFG = 0;
    localparam int IRQ_L1 = 1;
    localparam int IRQ_L0 = 2;
    localparam int IRQ_E = 3;
    localparam int IRQ_SP0 = 4;
    localparam int IRQ_SP1 = 5;
    localparam int FLAG_OF_CFG = 7;
    localparam int FLAG_OF_L1 = 6;
    localparam int FLAG_OF_L0 = 5;
    localparam int FLAG_OF_E = 4;
    localparam logic [IRQ_N-1:0] IRQ_FIXED_MASK = 6'h0E;
    localparam logic [IRQ_N-1:0] IRQ_FIXED_EDGE = 6'h08;
    // ************************************************************
    // Second serial port pin order
    // ************************************************************
    localparam int SP_SCLK = 0;
    localparam int SP_DR = 1;
    localparam int SP_RFS = 2;
    localparam int SP_DT = 3;
    localparam int SP_TFS = 4;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
    localparam logic [ADDR_W-1:0] ADDR_OE_HOST = 14'h0001;
    localparam logic [DATA_W-1:0] DATA_RST = 24'h000000;
    localparam logic [HOST_W-1:0] HOST_RST = 16'h0000;
    localparam logic [SP_W-1:0] SP_RST = 5'h00;
    localparam logic [IRQ_N-1:0] IRQ_RST = 6'h00;

    typedef enum logic {
        PH_CAPTURE,
        PH_RUN
    } rmp_phase_t;
endpackage

// ===== logic/rmp_irq_if.sv
// Carrier between the pin multiplexer and one interrupt detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rmp_irq_if;
    logic level_n;
    logic edge_mode;
    logic clear;
    logic req;
    modport det (
        input level_n,
        input edge_mode,
        input clear,
        output req
    );
    modport mux (
        output level_n,
        output edge_mode,
        output clear,
        input req
    );
endinterface

// ===== logic/rmp_sync.sv
// Two-stage synchroniser for every pin that arrives from outside.
// Assumes nothing; it has no reset so pin levels pass during reset.
`timescale 1ns/1ps
module rmp_sync (
    input wire logic clk,
    input wire logic [rmp_pkg::SYNC_W-1:0] async_in,
    output logic [rmp_pkg::SYNC_W-1:0] sync_out
);
    typedef struct packed {
        logic [rmp_pkg::SYNC_W-1:0] meta;
        logic [rmp_pkg::SYNC_W-1:0] stable;
    } rmp_sync_state_t;

    rmp_sync_state_t state_reg;
    rmp_sync_state_t state_next;

    always_comb begin
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end

    // No reset: mode levels must keep flowing while reset is held
    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    assign sync_out = state_reg.stable;
endmodule

// ===== logic/rmp_irq_det.sv
// Active-low interrupt detector, edge or level per its mode input.
// Assumes a synchronised level and a clear from the same clock.
`timescale 1ns/1ps
module rmp_irq_det (
    input wire logic clk,
    input wire logic rstn,
    rmp_irq_if.det irq
);
    typedef struct packed {
        logic prev;
        logic req;
    } rmp_det_state_t;

    rmp_det_state_t state_reg;
    rmp_det_state_t state_next;

    always_comb begin
        state_next.prev = irq.level_n;
        if (irq.edge_mode) begin
            // Set beats clear so a falling edge is never lost
            state_next.req = state_reg.req & ~irq.clear;
            if (state_reg.prev && !irq.level_n) begin
                state_next.req = 1'b1;
            end
        end else begin
            state_next.req = ~irq.level_n;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '{prev: 1'b1, req: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign irq.req = state_reg.req;
endmodule

// ===== sim/rmp_monitor.sv
// Port checker of the reset mode pin multiplexer.
// Assumes it is bound onto rmp_pin_mux; one clock domain.
`timescale 1ns/1ps
module rmp_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] flag_pin_in,
    input wire logic [7:0] flag_pin_oe,
    input wire logic [7:0] core_flag_dir,
    input wire logic [7:0] core_flag_in,
    input wire logic mode_host,
    input wire logic mode_b,
    input wire logic mode_a,
    input wire logic mode_valid,
    input wire logic [13:0] external_address_bus,
    input wire logic [13:0] external_address_oe,
    input wire logic [23:0] external_data_out,
    input wire logic [23:0] external_data_oe,
    input wire logic [13:0] core_addr,
    input wire logic core_byte_access,
    input wire logic [7:0] core_byte_addr_hi,
    input wire logic [15:0] host_port_addr_data_oe,
    input wire logic host_port_acknowledge_n,
    input wire logic host_port_acknowledge_oe,
    input wire logic core_host_ack,
    input wire logic [5:0] core_irq_req
);
    // ****
    // Properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_run;
        mode_valid && $past(mode_valid);
    endsequence
    // Pin low long enough to cross the synchroniser
    sequence s_fall4;
        mode_valid && !flag_pin_oe[4] && $fell(flag_pin_in[4])
            ##1 (!flag_pin_in[4] && !flag_pin_oe[4]) [*3];
    endsequence
    chk_mode_hold: assert property (s_run |-> $stable(mode_host)
        && $stable(mode_b) && $stable(mode_a)) else $error("mode moved");
    chk_flag_dir: assert property (s_run |->
        flag_pin_oe == $past(core_flag_dir)) else $error("flag oe");
    chk_flag_sample: assert property (
        mode_valid && $past(mode_valid, 2) |->
        core_flag_in == $past(flag_pin_in, 3)) else $error("flag in");
    chk_full_addr: assert property (s_run and !mode_host |->
        external_address_bus == $past(core_addr)
        && external_address_oe == 14'h3FFF) else $error("full address");
    chk_byte_hi: assert property (s_run and !mode_host
        and $past(core_byte_access) |-> &external_data_oe[23:16]
        && external_data_out[23:16] == $past(core_byte_addr_hi))
        else $error("byte address");
    chk_full_quiet: assert property (mode_valid && !mode_host |->
        host_port_addr_data_oe == 16'h0000 && !host_port_acknowledge_oe)
        else $error("host pins in full mode");
    chk_host_narrow: assert property (mode_valid && mode_host |->
        external_address_oe[13:1] == 13'h0000
        && external_data_oe[7:0] == 8'h00) else $error("host mode bus");
    chk_host_ack: assert property (s_run and mode_host |->
        host_port_acknowledge_oe
        && host_port_acknowledge_n == !$past(core_host_ack))
        else $error("host ack");
    chk_edge_irq: assert property (s_fall4 |->
        ##[1:2] core_irq_req[3]) else $error("edge irq missed");
endmodule
bind rmp_pin_mux rmp_monitor u_mon (.*);

// ===== sim/rmp_flag_partner.sv
// Far side of the flag pins: mode driver plus outside flag levels.
// Assumes the bench gives the outside levels; device drive wins.
`timescale 1ns/1ps
module rmp_flag_partner (
    input wire logic rstn,
    input wire logic [2:0] mode_lvl,
    input wire logic [7:0] ext_lvl,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_lvl
);
    logic [7:0] far;
    always_comb begin
        far = ext_lvl;
        // Mode driver floats once reset ends
        if (!rstn) begin
            far[2:0] = mode_lvl;
        end
        pin_lvl = (pin_oe & pin_out) | (~pin_oe & far);
    end
endmodule

// ===== sim/tb.sv
// Self-checking bench of the reset mode pin multiplexer.
// Assumes rmp_flag_partner on the flag pins, checker bound.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rstn = 1'b0;
    logic [7:0] flag_pin_in, flag_pin_out, flag_pin_oe, core_flag_in;
    logic [7:0] core_flag_dir = 8'h00, core_flag_out = 8'h00;
    logic [7:0] core_byte_addr_hi = 8'h00, ext_lvl = 8'hFF;
    logic [2:0] mode_lvl = 3'h0;
    logic mode_host, mode_b, mode_a, mode_valid, serial_alt_flag_input;
    logic [13:0] external_address_bus, external_address_oe;
    logic [13:0] core_addr = 14'h0000;
    logic [23:0] external_data_out, external_data_oe, core_data_in;
    logic [23:0] external_data_in = 24'hA5C3E1, core_data_out = 24'h000000;
    logic core_data_drive = 1'b0, core_byte_access = 1'b0;
    logic [15:0] host_port_addr_data_out, host_port_addr_data_oe;
    logic [15:0] host_port_addr_data_in = 16'h0000, core_host_data_in;
    logic [15:0] core_host_data_out = 16'h0000;
    logic host_port_write_enable_n = 1'b1, host_port_read_enable_n = 1'b1;
    logic host_port_address_latch = 1'b0, host_port_select_n = 1'b1;
    logic host_port_acknowledge_n, host_port_acknowledge_oe;
    logic core_host_data_drive = 1'b0, core_host_ack = 1'b0;
    logic core_host_write, core_host_read, core_host_latch, core_host_select;
    logic [4:0] second_serial_port_in = 5'h1F, second_serial_port_out;
    logic [4:0] second_serial_port_oe, core_sp_in;
    logic [4:0] core_sp_out = 5'h00, core_sp_oe = 5'h00;
    logic core_sp_alt = 1'b0, serial_alt_flag_output = 1'b0;
    logic [5:0] core_irq_edge = 6'h00, core_irq_clear = 6'h00, core_irq_req;
    int errors = 0, n_checks = 0;
    always #4 clk = ~clk;
    rmp_pin_mux uut (.*);
    rmp_flag_partner u_far (.rstn, .mode_lvl, .ext_lvl, .pin_out(flag_pin_out),
        .pin_oe(flag_pin_oe), .pin_lvl(flag_pin_in));
    // ****
    // Helpers
    // ****
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic do_reset(input logic [2:0] m);
        int i;
        rstn = 1'b0;
        mode_lvl = m;
        ext_lvl[2:0] = ~m;
        step(16);
        chk({flag_pin_oe, host_port_acknowledge_n}, 9'h001);
        rstn = 1'b1;
        for (i = 0; i < 8 && mode_valid !== 1'b1; i++) step(1);
        if (mode_valid !== 1'b1) begin
            errors++;
            $display("ERROR %0t mode never valid", $time);
            close_out();
        end
        chk({mode_host, mode_b, mode_a}, m);
        step(5);
        chk({mode_host, mode_b, mode_a}, m);
        chk(core_flag_in[2:0], 3'(~m));
    endtask
    task automatic t_full_bus();
        core_addr = 14'h2A5C;
        core_data_drive = 1'b1;
        core_byte_access = 1'b1;
        core_byte_addr_hi = 8'hC7;
        step(1);
        chk(external_address_bus, 14'h2A5C);
        chk(external_data_out[23:16], 8'hC7);
        chk(external_data_oe, 24'hFFFFFF);
        core_data_drive = 1'b0;
        core_byte_access = 1'b0;
        step(1);
        chk(external_data_oe, 24'h000000);
        chk(core_data_in, 24'hA5C3E1);
    endtask
    task automatic edge_case(input int pin, input int slot);
        ext_lvl[pin] = 1'b0;
        step(5);
        chk(core_irq_req[slot], 1'b1);
        ext_lvl[pin] = 1'b1;
        step(5);
        chk(core_irq_req[slot], 1'b1);
        core_irq_clear[slot] = 1'b1;
        step(1);
        core_irq_clear[slot] = 1'b0;
        step(3);
        chk(core_irq_req[slot], 1'b0);
    endtask
    task automatic t_irq();
        core_irq_edge[0] = 1'b1;
        edge_case(4, 3);
        edge_case(7, 0);
        ext_lvl[6] = 1'b0;
        step(5);
        chk(core_irq_req[1], 1'b1);
        ext_lvl[6] = 1'b1;
        core_flag_dir[5] = 1'b1;
        step(5);
        chk(core_irq_req[1:0], 2'b00);
        chk(core_irq_req[2], 1'b1);
        chk(flag_pin_out[5], 1'b0);
        core_flag_dir[5] = 1'b0;
        step(5);
        chk(core_irq_req[2], 1'b0);
    endtask
    task automatic t_serial();
        core_sp_alt = 1'b1;
        serial_alt_flag_output = 1'b1;
        second_serial_port_in = 5'h1B;
        step(5);
        chk({serial_alt_flag_input, core_sp_in}, 6'h3B);
        chk(second_serial_port_oe, 5'h08);
        chk(second_serial_port_out, 5'h08);
        chk(core_irq_req[4], 1'b1);
        core_sp_alt = 1'b0;
        step(5);
        chk({core_irq_req[4], second_serial_port_oe[3]}, 2'h0);
    endtask
    task automatic t_host_bus();
        core_addr = 14'h3FFF;
        core_data_out = 24'h00BEEF;
        core_data_drive = 1'b1;
        core_host_data_out = 16'h5A3C;
        core_host_data_drive = 1'b1;
        core_host_ack = 1'b1;
        host_port_write_enable_n = 1'b0;
        host_port_address_latch = 1'b1;
        host_port_select_n = 1'b0;
        host_port_addr_data_in = 16'h9E17;
        step(3);
        chk(external_address_oe, 14'h0001);
        chk(external_address_bus, 14'h0001);
        chk(external_data_out[23:8], 16'hBEEF);
        chk(external_data_oe, 24'hFFFF00);
        chk(core_data_in, 24'h00A5C3);
        chk(host_port_addr_data_oe, 16'hFFFF);
        chk(host_port_addr_data_out, 16'h5A3C);
        chk({core_host_write, core_host_read, core_host_latch,
            core_host_select, host_port_acknowledge_n}, 5'h16);
        chk(core_host_data_in, 16'h9E17);
    endtask
    initial begin
        do_reset(3'h2);
        t_full_bus();
        t_irq();
        t_serial();
        do_reset(3'h5);
        t_host_bus();
        close_out();
    end
endmodule
